// ==== core/crb_pkg.sv ====
// Shared constants and types for the call, return and branch unit.
package crb_pkg;

  // Widths of the program counter and stack pointer, and the number of port nibbles.
  localparam int PC_W   = 14;
  localparam int SP_W   = 8;
  localparam int PORT_N = 16;

  // Stack pointer value after reset; the stack grows downward from here.
  localparam logic [7:0] SP_RESET = 8'hFF;

  // Stack pointer steps for two-nibble and four-nibble stack frames.
  localparam logic [7:0] SP_STEP2 = 8'h02;
  localparam logic [7:0] SP_STEP4 = 8'h04;

  // Upper nibbles of the first opcode byte.
  localparam logic [3:0] HI_LONG_CALL = 4'h5;
  localparam logic [3:0] HI_ZP_CALL   = 4'hA;
  localparam logic [3:0] HI_BR_TRUE   = 4'hD;
  localparam logic [3:0] HI_BR_FALSE  = 4'h9;

  // Whole first opcode bytes.
  localparam logic [7:0] OP_BANK   = 8'h1B;
  localparam logic [7:0] OP_RET    = 8'h1C;
  localparam logic [7:0] OP_RETI   = 8'h1D;
  localparam logic [7:0] OP_PUSH   = 8'hCF;
  localparam logic [7:0] OP_POP    = 8'hCE;

  // Second-byte fields: push/pop prefix and branch test classes.
  localparam logic [4:0] PP_PREFIX = 5'h1F;
  localparam logic [1:0] TST_ACC   = 2'h0;
  localparam logic [1:0] TST_MEM   = 2'h1;
  localparam logic [1:0] TST_PORT  = 2'h2;
  localparam logic [3:0] TST_CARRY = 4'hC;
  localparam logic [3:0] TST_ZERO  = 4'hD;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ONE,
    ST_TWO
  } crb_state_t;

  // Instruction classes handled by the unit.
  typedef enum logic [3:0] {
    K_CALL,
    K_ZCALL,
    K_BANK,
    K_PUSH,
    K_POP,
    K_RET,
    K_RETI,
    K_BR,
    K_OTHER
  } crb_kind_t;

  // Complete register state of the unit.
  typedef struct packed {
    crb_state_t        st;
    crb_kind_t         kind;
    logic [SP_W-1:0]   sp;
    logic [15:0]       save;
    logic [PC_W-1:0]   target;
    logic [7:0]        hiPair;
    logic [1:0]        regSel;
    logic [SP_W-1:0]   ramAddr;
    logic              ramWe;
    logic [7:0]        ramWr;
    logic              busy;
    logic              done;
    logic              notMine;
    logic              pcLoad;
    logic [PC_W-1:0]   pcOut;
    logic              flagLoad;
    logic              carryOut;
    logic              zeroOut;
    logic              regLoad;
    logic [7:0]        regData;
    logic              bank;
    logic              afterBank;
    logic [63:0]       pinMeta;
    logic [63:0]       pinSync;
  } crb_regs_t;

endpackage

// ==== core/crb_bit_test.sv ====
// Branch condition evaluator for the in-page conditional branches.
`timescale 1ns/100ps

module crb_bit_test (
  // Opcode bytes.
  input  wire logic [7:0] op0,
  input  wire logic [7:0] op1,
  // Tested operands.
  input  wire logic [3:0] accIn,
  input  wire logic [3:0] memIn,
  input  wire logic [3:0] portIn,
  input  wire logic       carryIn,
  input  wire logic       zeroIn,
  // Results.
  output logic            isBranch,
  output logic            taken
);

  logic       polarity;  // High when the branch fires on a one.
  logic       tested;    // The bit or flag under test.
  logic       known;     // The second byte names a valid test.
  logic [1:0] bitSel;    // Bit selector of bit tests.

  // Pick the tested bit, then compare it with the opcode's polarity.
  always_comb begin
    polarity = (op0[7:4] == crb_pkg::HI_BR_TRUE);
    bitSel   = op1[5:4];
    known    = 1'b1;
    tested   = 1'b0;
    if (op1[7:6] == crb_pkg::TST_ACC) begin
      tested = accIn[bitSel];
    end else if (op1[7:6] == crb_pkg::TST_MEM) begin
      tested = memIn[bitSel];
    end else if (op1[7:6] == crb_pkg::TST_PORT) begin
      tested = portIn[bitSel];
    end else if (op1[7:4] == crb_pkg::TST_CARRY) begin
      tested = carryIn;
    end else if (op1[7:4] == crb_pkg::TST_ZERO) begin
      tested = zeroIn;
    end else begin
      known = 1'b0;
    end
    isBranch = known && (polarity || (op0[7:4] == crb_pkg::HI_BR_FALSE));
    taken    = isBranch && (tested == polarity);
  end

endmodule

// ==== core/crb_unit.sv ====
// Call, return, stack and in-page branch execution unit of a 4-bit controller.
// Operation
// - Long call saves flags and PC, jumps
// - Zero-page call saves frame, targets page zero
// - Bank opcode switches memory and register banks
// - Push writes register pair, SP minus two
// - Pop reads at SP plus two, loads and raises SP together
// - Return restores PC, keeps carry and zero
// - Interrupt return also restores carry and zero
// - Accumulator bit branch on one or zero
// - Memory nibble bit branch at data pointer
// - Port bit branch on selected port nibble
// - Right after bank change, port branch reads controls
// - Carry branch on set or clear carry
// - Zero branch on set or clear zero
// - Taken branch replaces only PC low byte
`timescale 1ns/100ps

module crb_unit (
  // Clock and synchronous reset.
  input  wire logic        clk,
  input  wire logic        srst,
  // Instruction hand-off from the fetch stage.
  input  wire logic        start,
  input  wire logic [7:0]  op0,
  input  wire logic [7:0]  op1,
  input  wire logic [13:0] pcNext,
  // Core state read by the unit.
  input  wire logic        carryIn,
  input  wire logic        zeroIn,
  input  wire logic [3:0]  accIn,
  input  wire logic [3:0]  memIn,
  input  wire logic [3:0]  pointerLowNibble,
  input  wire logic [31:0] regPairs,
  input  wire logic [63:0] ctrlRegs,
  input  wire logic [63:0] portPins,
  // Stack RAM, two nibbles per access.
  output logic [7:0]       ramAddr,
  output logic             ramWe,
  output logic [7:0]       ramWrData,
  input  wire logic [7:0]  ramRdData,
  // Results returned to the core.
  output logic             busy,
  output logic             done,
  output logic             notMine,
  output logic             pcLoad,
  output logic [13:0]      pcOut,
  output logic             flagLoad,
  output logic             carryOut,
  output logic             zeroOut,
  output logic             regLoad,
  output logic [1:0]       regSel,
  output logic [7:0]       regData,
  output logic             bankSel,
  output logic [7:0]       stackPtr
);

  crb_pkg::crb_regs_t q;         // Registered state.
  crb_pkg::crb_regs_t d;         // Next state.
  logic [3:0]         portNib;   // Nibble seen by port branches.
  logic [5:0]         portIdx;   // Bit offset of the selected nibble.
  logic               isBranch;  // Opcode is a conditional branch.
  logic               brTaken;   // Branch condition holds.

  // Port nibble selection; right after a bank change the control
  // registers are visible instead of the synchronised pins.
  always_comb begin
    portIdx = {pointerLowNibble, 2'b00};
    if (q.afterBank) begin
      portNib = ctrlRegs[portIdx +: 4];
    end else begin
      portNib = q.pinSync[portIdx +: 4];
    end
  end

  // Condition evaluation for the branch group.
  crb_bit_test u_test (
    .op0      (op0),
    .op1      (op1),
    .accIn    (accIn),
    .memIn    (memIn),
    .portIn   (portNib),
    .carryIn  (carryIn),
    .zeroIn   (zeroIn),
    .isBranch (isBranch),
    .taken    (brTaken)
  );

  // Next-state logic: decode in idle, then one or two execution cycles.
  always_comb begin
    d          = q;
    d.done     = 1'b0;
    d.notMine  = 1'b0;
    d.pcLoad   = 1'b0;
    d.flagLoad = 1'b0;
    d.regLoad  = 1'b0;
    d.ramWe    = 1'b0;
    // Port pins come from outside and pass two flip-flops.
    d.pinMeta  = portPins;
    d.pinSync  = q.pinMeta;
    case (q.st)
      crb_pkg::ST_IDLE: begin
        if (start) begin
          d.st   = crb_pkg::ST_ONE;
          d.busy = 1'b1;
          d.save = {carryIn, zeroIn, pcNext};
          d.regSel = op1[2:1];
          if (op0[7:4] == crb_pkg::HI_LONG_CALL && !op1[7]) begin
            // First half of the frame: flags, PC13..8 at SP.
            d.kind    = crb_pkg::K_CALL;
            d.target  = {pcNext[13], 2'b00, op1[6:4], op0[3:0], op1[3:0]};
            d.ramWe   = 1'b1;
            d.ramAddr = q.sp;
            d.ramWr   = {carryIn, zeroIn, pcNext[13:8]};
          end else if (op0[7:4] == crb_pkg::HI_ZP_CALL) begin
            d.kind    = crb_pkg::K_ZCALL;
            d.target  = {8'h00, op0[3:0], 2'b00};
            d.ramWe   = 1'b1;
            d.ramAddr = q.sp;
            d.ramWr   = {carryIn, zeroIn, pcNext[13:8]};
          end else if (op0 == crb_pkg::OP_BANK) begin
            d.kind = crb_pkg::K_BANK;
          end else if ((op0 == crb_pkg::OP_PUSH) && (op1[7:3] == crb_pkg::PP_PREFIX)
                       && !op1[0]) begin
            // The selected pair goes high nibble at SP, low at SP-1.
            d.kind    = crb_pkg::K_PUSH;
            d.ramWe   = 1'b1;
            d.ramAddr = q.sp;
            d.ramWr   = regPairs[{op1[2:1], 3'b000} +: 8];
          end else if ((op0 == crb_pkg::OP_POP) && (op1[7:3] == crb_pkg::PP_PREFIX)
                       && !op1[0]) begin
            d.kind    = crb_pkg::K_POP;
            d.ramAddr = q.sp + crb_pkg::SP_STEP2;
          end else if (op0 == crb_pkg::OP_RET || op0 == crb_pkg::OP_RETI) begin
            d.kind    = (op0 == crb_pkg::OP_RET) ? crb_pkg::K_RET : crb_pkg::K_RETI;
            d.ramAddr = q.sp + crb_pkg::SP_STEP4;
          end else if (isBranch) begin
            // Condition is sampled now; taken or not, only the PC moves.
            d.kind = crb_pkg::K_BR;
            if (brTaken) begin
              d.target = {pcNext[13:8], op0[3:0], op1[3:0]};
            end else begin
              d.target = pcNext;
            end
          end else begin
            d.kind = crb_pkg::K_OTHER;
          end
        end
      end
      crb_pkg::ST_ONE: begin
        d.st = crb_pkg::ST_TWO;
        case (q.kind)
          crb_pkg::K_CALL, crb_pkg::K_ZCALL: begin
            // Second half of the frame: PC7..0 at SP-2.
            d.ramWe   = 1'b1;
            d.ramAddr = q.sp - crb_pkg::SP_STEP2;
            d.ramWr   = q.save[7:0];
          end
          crb_pkg::K_POP: begin
            d.regData = ramRdData;
          end
          crb_pkg::K_RET, crb_pkg::K_RETI: begin
            d.hiPair  = ramRdData;
            d.ramAddr = q.sp + crb_pkg::SP_STEP2;
          end
          crb_pkg::K_BANK: begin
            // One-cycle opcode; the next instruction sees the new bank.
            d.st        = crb_pkg::ST_IDLE;
            d.busy      = 1'b0;
            d.done      = 1'b1;
            d.bank      = ~q.bank;
            d.afterBank = 1'b1;
          end
          crb_pkg::K_OTHER: begin
            // Not in this group: hand it straight back.
            d.st        = crb_pkg::ST_IDLE;
            d.busy      = 1'b0;
            d.done      = 1'b1;
            d.notMine   = 1'b1;
            d.afterBank = 1'b0;
          end
          default: begin
            d.st = crb_pkg::ST_TWO;
          end
        endcase
      end
      crb_pkg::ST_TWO: begin
        d.st        = crb_pkg::ST_IDLE;
        d.busy      = 1'b0;
        d.done      = 1'b1;
        d.afterBank = 1'b0;
        case (q.kind)
          crb_pkg::K_CALL, crb_pkg::K_ZCALL: begin
            d.sp     = q.sp - crb_pkg::SP_STEP4;
            d.pcLoad = 1'b1;
            d.pcOut  = q.target;
          end
          crb_pkg::K_PUSH: begin
            d.sp = q.sp - crb_pkg::SP_STEP2;
          end
          crb_pkg::K_POP: begin
            d.sp      = q.sp + crb_pkg::SP_STEP2;
            d.regLoad = 1'b1;
          end
          crb_pkg::K_RET, crb_pkg::K_RETI: begin
            d.sp     = q.sp + crb_pkg::SP_STEP4;
            d.pcLoad = 1'b1;
            d.pcOut  = {q.hiPair[5:0], ramRdData};
            if (q.kind == crb_pkg::K_RETI) begin
              d.flagLoad = 1'b1;
              d.carryOut = q.hiPair[7];
              d.zeroOut  = q.hiPair[6];
            end
          end
          crb_pkg::K_BR: begin
            d.pcLoad = 1'b1;
            d.pcOut  = q.target;
          end
          default: begin
            d.notMine = 1'b0;
          end
        endcase
      end
      default: begin
        d.st   = crb_pkg::ST_IDLE;
        d.busy = 1'b0;
      end
    endcase
  end

  // State register with synchronous reset to constants.
  always_ff @(posedge clk) begin
    if (srst) begin
      q    <= '0;
      q.st <= crb_pkg::ST_IDLE;
      q.kind <= crb_pkg::K_OTHER;
      q.sp <= crb_pkg::SP_RESET;
    end else begin
      q <= d;
    end
  end

  // Outputs come straight from the state register.
  assign ramAddr   = q.ramAddr;
  assign ramWe     = q.ramWe;
  assign ramWrData = q.ramWr;
  assign busy      = q.busy;
  assign done      = q.done;
  assign notMine   = q.notMine;
  assign pcLoad    = q.pcLoad;
  assign pcOut     = q.pcOut;
  assign flagLoad  = q.flagLoad;
  assign carryOut  = q.carryOut;
  assign zeroOut   = q.zeroOut;
  assign regLoad   = q.regLoad;
  assign regSel    = q.regSel;
  assign regData   = q.regData;
  assign bankSel   = q.bank;
  assign stackPtr  = q.sp;

endmodule

// ==== test/crb_monitor.sv ====
// Port checker for the call, return and branch unit.
`timescale 1ns/100ps
module crb_monitor (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        srst,
  // Requests.
  input wire logic        start,
  input wire logic [7:0]  op0,
  input wire logic [7:0]  op1,
  input wire logic [13:0] pcNext,
  input wire logic [31:0] regPairs,
  // Results.
  input wire logic        busy,
  input wire logic        done,
  input wire logic        pcLoad,
  input wire logic [13:0] pcOut,
  input wire logic        flagLoad,
  input wire logic        regLoad,
  input wire logic [7:0]  ramAddr,
  input wire logic        ramWe,
  input wire logic [7:0]  ramWrData,
  input wire logic        bankSel,
  input wire logic [7:0]  stackPtr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // A request counts only when the unit is idle.
  logic        go;
  logic [7:0]  op0Q;   // First opcode byte of the request in flight.
  logic [7:0]  op1Q;   // Second opcode byte of the request in flight.
  logic [13:0] pcQ;    // Follow-on address of the request in flight.
  logic [7:0]  pairQ;  // Register pair selected by the request in flight.
  assign go = start && !busy;
  // Hold the fields of each accepted request until the next one is taken.
  always_ff @(posedge clk) begin
    if (go) begin
      op0Q  <= op0;
      op1Q  <= op1;
      pcQ   <= pcNext;
      pairQ <= regPairs[{op1[2:1], 3'b000} +: 8];
    end
  end
  // Zero-page call target is built from the low opcode nibble.
  property p_zc;
    go && op0[7:4] == crb_pkg::HI_ZP_CALL
      |-> ##3 pcLoad && pcOut == {8'h00, op0Q[3:0], 2'b00};
  endproperty
  // Push writes the selected pair at the stack pointer.
  property p_push;
    go && op0 == crb_pkg::OP_PUSH && op1[7:3] == crb_pkg::PP_PREFIX && !op1[0]
      |=> ramWe && ramWrData == pairQ && ramAddr == stackPtr ##2 done;
  endproperty
  // A branch only ever touches the low PC byte.
  property p_br;
    go && (op0[7:4] == crb_pkg::HI_BR_TRUE || op0[7:4] == crb_pkg::HI_BR_FALSE)
      && op1[7:5] != 3'b111
      |-> ##3 pcLoad && !regLoad && !flagLoad && pcOut[13:8] == pcQ[13:8]
      && (pcOut == pcQ || pcOut[7:0] == {op0Q[3:0], op1Q[3:0]});
  endproperty
  a_done_time: assert property (go |=> !done ##[1:2] done) else $error("done late");
  a_call_frame: assert property (go && !op1[7]
    && op0[7:4] == crb_pkg::HI_LONG_CALL |=> ramWe && ramAddr == stackPtr
    ##1 ramWe && ramAddr == stackPtr - 8'h02) else $error("bad call frame");
  a_call_sp: assert property (go && op0[7:4] == crb_pkg::HI_LONG_CALL
    && !op1[7] |-> ##3 done && pcLoad
    && stackPtr == $past(stackPtr, 3) - crb_pkg::SP_STEP4) else $error("bad call sp");
  a_zcall_pc: assert property (p_zc) else $error("bad zero-page target");
  a_push_data: assert property (p_push) else $error("bad push write");
  a_pop_sp: assert property (go && op0 == crb_pkg::OP_POP && !op1[0]
    && op1[7:3] == crb_pkg::PP_PREFIX |-> ##3 regLoad
    && stackPtr == $past(stackPtr, 3) + crb_pkg::SP_STEP2) else $error("bad pop sp");
  a_ret_keep: assert property (go && op0 == crb_pkg::OP_RET |-> ##3 pcLoad && !flagLoad
    && stackPtr == $past(stackPtr, 3) + crb_pkg::SP_STEP4) else $error("bad return");
  a_reti_flags: assert property (go && op0 == crb_pkg::OP_RETI
    |=> ramAddr == stackPtr + 8'h04 ##2 flagLoad) else $error("bad interrupt return");
  a_bank_flip: assert property (go && op0 == crb_pkg::OP_BANK |-> ##2 done
    && bankSel != $past(bankSel, 2)) else $error("bank not switched");
  a_branch_page: assert property (p_br) else $error("bad branch target");
  // Main scenarios.
  c_reti: cover property (go && op0 == crb_pkg::OP_RETI);
  c_pop: cover property (go && op0 == crb_pkg::OP_POP);
  c_flag: cover property (flagLoad);
endmodule

// ==== test/crb_stack_ram.sv ====
// Behavioural stack RAM, two nibbles per access.
`timescale 1ns/100ps
module crb_stack_ram (
  // Clock.
  input  wire logic       clk,
  // Access from the unit.
  input  wire logic [7:0] ramAddr,
  input  wire logic       ramWe,
  input  wire logic [7:0] ramWrData,
  output logic      [7:0] ramRdData
);
  // Nibble cells; unwritten ones hold a pattern unlike stored data.
  logic [3:0] mem [256];
  initial for (int i = 0; i < 256; i++) mem[i] = 4'(i) ^ 4'hA;
  // Read nibble A high and A-1 low, same cycle.
  assign ramRdData = {mem[ramAddr], mem[8'(ramAddr - 8'h01)]};
  // Write both nibbles on the edge.
  always @(posedge clk) begin
    if (ramWe) begin
      mem[ramAddr] <= ramWrData[7:4];
      mem[8'(ramAddr - 8'h01)] <= ramWrData[3:0];
    end
  end
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the call, return and branch unit.
`timescale 1ns/100ps
module testbench;
  // Inputs of the unit.
  logic clk = 1'b0, srst = 1'b1, start = 1'b0, carryIn = 1'b0, zeroIn = 1'b0;
  logic [7:0] op0 = 8'h00, op1 = 8'h00;
  logic [13:0] pcNext = 14'h0000;
  logic [3:0] accIn = 4'h5, memIn = 4'h3, pointerLowNibble = 4'h3;
  logic [31:0] regPairs = 32'hD4C3B2A1;
  logic [63:0] ctrlRegs = 64'h6000, portPins = 64'h9000;
  // Outputs of the unit.
  logic [7:0] ramAddr, ramWrData, ramRdData, regData, stackPtr;
  logic ramWe, busy, done, notMine, pcLoad, flagLoad, carryOut, zeroOut, regLoad, bankSel;
  logic [13:0] pcOut;
  logic [1:0] regSel;
  int failures = 0, n_tests = 0, cyc = 0;
  // Clock of 100 ns.
  always #50 clk = ~clk;
  crb_unit dut (
    .clk              (clk),
    .srst             (srst),
    .start            (start),
    .op0              (op0),
    .op1              (op1),
    .pcNext           (pcNext),
    .carryIn          (carryIn),
    .zeroIn           (zeroIn),
    .accIn            (accIn),
    .memIn            (memIn),
    .pointerLowNibble (pointerLowNibble),
    .regPairs         (regPairs),
    .ctrlRegs         (ctrlRegs),
    .portPins         (portPins),
    .ramAddr          (ramAddr),
    .ramWe            (ramWe),
    .ramWrData        (ramWrData),
    .ramRdData        (ramRdData),
    .busy             (busy),
    .done             (done),
    .notMine          (notMine),
    .pcLoad           (pcLoad),
    .pcOut            (pcOut),
    .flagLoad         (flagLoad),
    .carryOut         (carryOut),
    .zeroOut          (zeroOut),
    .regLoad          (regLoad),
    .regSel           (regSel),
    .regData          (regData),
    .bankSel          (bankSel),
    .stackPtr         (stackPtr)
  );
  crb_stack_ram ram (
    .clk       (clk),
    .ramAddr   (ramAddr),
    .ramWe     (ramWe),
    .ramWrData (ramWrData),
    .ramRdData (ramRdData)
  );
  // Compare and count.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask
  // Hand over one instruction and wait for done at the given cycle.
  task run(input logic [7:0] a, input logic [7:0] b, input logic [13:0] pc,
           input logic [1:0] cz, input int lat);
    int n;
    @(posedge clk);
    start <= 1'b1;
    op0 <= a;
    op1 <= b;
    pcNext <= pc;
    {carryIn, zeroIn} <= cz;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n == 1) chk(busy, 1'b1);
    end while (done !== 1'b1 && n < 9);
    chk(n, lat);
  endtask
  // Nested calls unwound by both returns.
  task t_call;
    run(8'h5A, 8'h3C, 14'h2ABC, 2'b10, 3);
    chk({stackPtr, pcOut}, {8'hFB, 14'h23AC});
    run(8'hA5, 8'h00, 14'h0111, 2'b01, 3);
    chk({stackPtr, pcOut}, {8'hF7, 14'h0014});
    run(crb_pkg::OP_RET, 8'h00, 14'h0000, 2'b00, 3);
    chk({flagLoad, stackPtr, pcOut}, {1'b0, 8'hFB, 14'h0111});
    run(crb_pkg::OP_RETI, 8'h00, 14'h0000, 2'b00, 3);
    chk({flagLoad, carryOut, zeroOut, stackPtr, pcOut}, {3'b110, 8'hFF, 14'h2ABC});
    $display("call test done");
  endtask
  // Two pushes, then pops in reverse order.
  task t_stack;
    run(crb_pkg::OP_PUSH, 8'hFC, 14'h0000, 2'b00, 3);
    @(posedge clk);
    regPairs <= 32'h11223344;
    run(crb_pkg::OP_PUSH, 8'hFA, 14'h0000, 2'b00, 3);
    chk(stackPtr, 8'hFB);
    run(crb_pkg::OP_POP, 8'hFE, 14'h0000, 2'b00, 3);
    chk({regLoad, regSel, regData, stackPtr}, {3'b111, 8'h33, 8'hFD});
    run(crb_pkg::OP_POP, 8'hF8, 14'h0000, 2'b00, 3);
    chk({regLoad, regSel, regData, stackPtr}, {3'b100, 8'hC3, 8'hFF});
    $display("stack test done");
  endtask
  // Every branch class, sense and bit.
  task t_branch;
    logic [7:0] b;
    logic v;
    logic [13:0] e;
    for (int h = 0; h < 2; h++) for (int c = 0; c < 5; c++) for (int t = 0; t < 4; t++) begin
      b = (c < 3) ? {2'(c), 2'(t), 4'h6} : {(c == 3) ? 4'hC : 4'hD, 4'h6};
      v = (c == 0) ? accIn[t] : (c == 1) ? memIn[t] : (c == 2) ? portPins[12+t] : (c == 3);
      e = (v ^ h[0]) ? 14'h34A6 : 14'h3456;
      run({h ? 4'h9 : 4'hD, 4'hA}, b, 14'h3456, 2'b10, 3);
      chk(pcOut, e);
      chk({regLoad, flagLoad, stackPtr}, {2'b00, 8'hFF});
    end
    $display("branch test done");
  endtask
  // Bank switch, control-register test and a foreign opcode.
  task t_bank;
    logic b0;
    b0 = bankSel;
    run(crb_pkg::OP_BANK, 8'h00, 14'h0000, 2'b00, 2);
    chk(bankSel, !b0);
    run(8'hDA, 8'h96, 14'h3456, 2'b00, 3);
    chk(pcOut, 14'h34A6);
    run(8'hDA, 8'h96, 14'h3456, 2'b00, 3);
    chk(pcOut, 14'h3456);
    run(8'h00, 8'h00, 14'h0000, 2'b00, 2);
    chk({notMine, pcLoad}, 2'b10);
    $display("bank test done");
  endtask
  // Verdict and end of run.
  task final_report;
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Cut a hang short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      final_report;
    end
  end
  // Main sequence.
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk(stackPtr, crb_pkg::SP_RESET);
    t_call;
    t_stack;
    t_branch;
    t_bank;
    final_report;
  end
endmodule
bind crb_unit crb_monitor mon (
  .clk       (clk),
  .srst      (srst),
  .start     (start),
  .op0       (op0),
  .op1       (op1),
  .pcNext    (pcNext),
  .regPairs  (regPairs),
  .busy      (busy),
  .done      (done),
  .pcLoad    (pcLoad),
  .pcOut     (pcOut),
  .flagLoad  (flagLoad),
  .regLoad   (regLoad),
  .ramAddr   (ramAddr),
  .ramWe     (ramWe),
  .ramWrData (ramWrData),
  .bankSel   (bankSel),
  .stackPtr  (stackPtr)
);
